// File: hbfs_consts.svh
// constant offsets, bit positions and timing counts of the fault supervisor
`ifndef HBFS_CONSTS_SVH
`define HBFS_CONSTS_SVH
`define HBFS_BRIDGES       6
`define HBFS_CMD_OVERVOLTAGE_LOCKOUT_ENABLE      0
`define HBFS_CMD_CFG_LSB   1
`define HBFS_CMD_EN_LSB    7
`define HBFS_CMD_UNDERLOAD_SHUTDOWN_CTRL     13
`define HBFS_CMD_SRR       15
`define HBFS_ST_TW         0
`define HBFS_ST_CFG_LSB    1
`define HBFS_ST_EN_LSB     7
`define HBFS_ST_UL         13
`define HBFS_ST_PSF        14
`define HBFS_ST_OC         15
`define HBFS_FRAME_BITS    16
`define HBFS_FRAME_WRAP    23
`define HBFS_CLK_NS        50
`define HBFS_OC_FILT_NS    10000
`define HBFS_UL_FILT_NS    200000
`define HBFS_OC_FILT_CYC   ((`HBFS_OC_FILT_NS+`HBFS_CLK_NS-1)/`HBFS_CLK_NS)
`define HBFS_UL_FILT_CYC   ((`HBFS_UL_FILT_NS+`HBFS_CLK_NS-1)/`HBFS_CLK_NS)
`endif

// File: hbfs_pkg.sv
// types shared by the half-bridge fault supervisor
package hbfs_pkg;
    typedef logic [5:0] bridge_vec_t;
    typedef enum logic [1:0] {
        HB_CODE_OK = 2'h0,
        HB_CODE_OC = 2'h1,
        HB_CODE_UL = 2'h2
    } hb_code_t;
    typedef enum logic [1:0] {
        UL_IDLE = 2'h1,
        UL_RUN  = 2'h2
    } ul_state_t;
endpackage

// File: half_bridge_fault_supervisor.sv
// fault supervisor for a six channel half-bridge driver
`timescale 1ns/1ps
`default_nettype none
`include "hbfs_consts.svh"
module half_bridge_fault_supervisor (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                link_sclk,
    input  wire logic                spi_cs_n,
    input  wire logic                spi_si,
    input  wire logic                en_pin,
    input  wire logic                vcc_uv,
    input  wire logic                vs_uv,
    input  wire logic                vs_ov,
    input  wire hbfs_pkg::bridge_vec_t oc_det,
    input  wire hbfs_pkg::bridge_vec_t ul_det,
    input  wire hbfs_pkg::bridge_vec_t tw_det,
    input  wire hbfs_pkg::bridge_vec_t tsd_det,
    output logic [5:0]               hs_on_r,
    output logic [5:0]               ls_on_r,
    output logic [15:0]              status_r,
    output logic [11:0]              hb_code_r,
    output logic                     tsd_flag_r,
    output logic                     frame_applied_r
);

////////////////////////////////////////////////////////////////////////////
// link domain: bit counter, shift path, frame marker

logic [4:0]  lk_cnt_r;
logic [4:0]  lk_cnt_nxt;
logic [15:0] lk_shift_r;
logic        lk_ok_r;
logic        lk_tgl_r;

// wraps 16 -> 23 -> 16 so that 16 + n*8 bits all land on 16
assign lk_cnt_nxt = (lk_cnt_r == 5'(`HBFS_FRAME_WRAP)) ?
                    5'(`HBFS_FRAME_BITS) : lk_cnt_r + 5'h1;

// chip select high clears the count; the link clock stops between frames
always_ff @(posedge link_sclk or posedge spi_cs_n or posedge rst) begin
    if (rst || spi_cs_n) begin
        lk_cnt_r <= 5'h0;
    end else begin
        lk_cnt_r <= lk_cnt_nxt;
    end
end

// shift path, validity and a toggle marking each frame's first bit
always_ff @(posedge link_sclk or posedge rst) begin
    if (rst) begin
        lk_shift_r <= 16'h0;
        lk_ok_r    <= 1'b0;
        lk_tgl_r   <= 1'b0;
    end else begin
        lk_shift_r <= {lk_shift_r[14:0], spi_si};
        lk_ok_r    <= (lk_cnt_nxt == 5'(`HBFS_FRAME_BITS));
        if (lk_cnt_r == 5'h0) begin
            lk_tgl_r <= ~lk_tgl_r;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// synchronisers into the device clock

localparam int SW = 30;
logic [SW-1:0] sy1_r;
logic [SW-1:0] sy2_r;
logic          cs_q3_r;
logic          tgl_seen_r;

// two flops for the select, enable, supply and detector levels and for the frame toggle
always_ff @(posedge clk) begin
    if (rst) begin
        sy1_r <= {1'b1, {(SW-1){1'b0}}}; // select idles high: no false edge
        sy2_r <= {1'b1, {(SW-1){1'b0}}};
    end else begin
        sy1_r <= {spi_cs_n, lk_tgl_r, en_pin, vcc_uv, vs_uv, vs_ov,
                  oc_det, ul_det, tw_det, tsd_det};
        sy2_r <= sy1_r;
    end
end

logic                  cs_s, tgl_s, en_s, vcc_uv_s, vs_uv_s, vs_ov_s;
hbfs_pkg::bridge_vec_t oc_s, ul_s, tw_s, tsd_s;
assign {cs_s, tgl_s, en_s, vcc_uv_s, vs_uv_s, vs_ov_s,
        oc_s, ul_s, tw_s, tsd_s} = sy2_r;

// end of frame: shift data and validity are frozen while select is high
logic cs_rise;
logic frame_take;
logic status_reset_request;
assign cs_rise    = cs_s && !cs_q3_r;
assign frame_take = cs_rise && (tgl_s != tgl_seen_r) && lk_ok_r;
assign status_reset_request        = frame_take && lk_shift_r[`HBFS_CMD_SRR];

always_ff @(posedge clk) begin
    if (rst) begin
        cs_q3_r    <= 1'b1;
        tgl_seen_r <= 1'b0;
    end else begin
        cs_q3_r <= cs_s;
        if (cs_rise) begin
            tgl_seen_r <= tgl_s;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// command store and fault latches

logic [5:0] cmd_en_r, cmd_cfg_r, off_latch_r;
logic       cmd_overvoltage_lockout_enable_r, cmd_underload_shutdown_ctrl_r;
logic       oc_flag_r, ul_flag_r;
logic [5:0] oc_trip, ul_trip, ul_hit, tsd_trip, trip;
logic       wipe;
logic       lat_clr;

// logic undervoltage wipes command, latches, filters and outputs (not the link or frame edge flops); enable low acts as a latch clear
assign wipe    = vcc_uv_s;
assign lat_clr = status_reset_request || !en_s;
assign trip    = oc_trip | ul_trip | tsd_trip;

// frames load the command; a trip zeroes its bridge even in the load cycle
always_ff @(posedge clk) begin
    if (rst || wipe) begin
        cmd_en_r    <= 6'h0;
        cmd_cfg_r   <= 6'h0;
        cmd_overvoltage_lockout_enable_r  <= 1'b0;
        cmd_underload_shutdown_ctrl_r <= 1'b0;
    end else begin
        if (frame_take) begin
            cmd_en_r    <= lk_shift_r[`HBFS_CMD_EN_LSB +: 6] & ~trip;
            cmd_cfg_r   <= lk_shift_r[`HBFS_CMD_CFG_LSB +: 6] & ~trip;
            cmd_overvoltage_lockout_enable_r  <= lk_shift_r[`HBFS_CMD_OVERVOLTAGE_LOCKOUT_ENABLE];
            cmd_underload_shutdown_ctrl_r <= lk_shift_r[`HBFS_CMD_UNDERLOAD_SHUTDOWN_CTRL];
        end else begin
            cmd_en_r  <= cmd_en_r & ~trip;
            cmd_cfg_r <= cmd_cfg_r & ~trip;
        end
    end
end

// latched flags: a set in the clearing cycle survives
always_ff @(posedge clk) begin
    if (rst || wipe) begin
        off_latch_r <= 6'h0;
        oc_flag_r   <= 1'b0;
        ul_flag_r   <= 1'b0;
        tsd_flag_r  <= 1'b0;
    end else begin
        off_latch_r <= (lat_clr ? (tsd_s & off_latch_r) : off_latch_r)
                       | trip;
        oc_flag_r   <= (oc_flag_r && !lat_clr) || (|oc_trip);
        ul_flag_r   <= (ul_flag_r && !lat_clr)
                       || (|(ul_trip | ul_hit));
        tsd_flag_r  <= (tsd_flag_r && !(lat_clr && !(|tsd_s)))
                       || (|tsd_trip);
    end
end

////////////////////////////////////////////////////////////////////////////
// overcurrent filters, one per output

logic [7:0] oc_cnt_r [6];
logic [5:0] drive_hs, drive_ls, ls_active;

// count reached on the cycle the filter time has fully elapsed
function automatic logic filt_done(input logic [11:0] cnt,
                                   input logic [11:0] lim);
    filt_done = (cnt == lim - 12'h1);
endfunction

always_ff @(posedge clk) begin
    if (rst || wipe) begin
        for (int i = 0; i < 6; i++) begin
            oc_cnt_r[i] <= 8'h0;
        end
    end else begin
        for (int i = 0; i < 6; i++) begin
            if (oc_s[i] && (drive_hs[i] || drive_ls[i]) && !oc_trip[i]) begin
                oc_cnt_r[i] <= oc_cnt_r[i] + 8'h1;
            end else begin
                oc_cnt_r[i] <= 8'h0;
            end
        end
    end
end

always_comb begin
    for (int i = 0; i < 6; i++) begin
        oc_trip[i] = oc_s[i] && (drive_hs[i] || drive_ls[i]) &&
                     filt_done({4'h0, oc_cnt_r[i]},
                               12'(`HBFS_OC_FILT_CYC));
    end
end

////////////////////////////////////////////////////////////////////////////
// underload: one shared timer for all low sides

hbfs_pkg::ul_state_t ul_st_r;
logic [11:0]         ul_cnt_r;
logic                ul_any;

assign ls_active = drive_ls;
assign ul_any    = |(ul_s & ls_active);

// timer starts at the first underload; later ones share its remainder
always_ff @(posedge clk) begin
    if (rst || wipe) begin
        ul_st_r  <= hbfs_pkg::UL_IDLE;
        ul_cnt_r <= 12'h0;
    end else begin
        case (ul_st_r)
            hbfs_pkg::UL_IDLE: begin
                ul_cnt_r <= 12'h0;
                if (ul_any) begin
                    ul_st_r <= hbfs_pkg::UL_RUN;
                end
            end
            hbfs_pkg::UL_RUN: begin
                if (!ul_any || filt_done(ul_cnt_r,
                                         12'(`HBFS_UL_FILT_CYC))) begin
                    ul_st_r  <= hbfs_pkg::UL_IDLE;
                    ul_cnt_r <= 12'h0;
                end else begin
                    ul_cnt_r <= ul_cnt_r + 12'h1;
                end
            end
            default: begin
                ul_st_r  <= hbfs_pkg::UL_IDLE;
                ul_cnt_r <= 12'h0;
            end
        endcase
    end
end

// expiry catches every driven low side that reports underload at that moment
assign ul_hit  = (ul_st_r == hbfs_pkg::UL_RUN &&
                  filt_done(ul_cnt_r, 12'(`HBFS_UL_FILT_CYC))) ?
                 (ul_s & ls_active) : 6'h0;
assign ul_trip = cmd_underload_shutdown_ctrl_r ? ul_hit : 6'h0;

// shutdown sensors latch their own bridge only
assign tsd_trip = tsd_s & (cmd_en_r | off_latch_r) & ~off_latch_r;

////////////////////////////////////////////////////////////////////////////
// driver outputs and status

logic allow;
logic [11:0] code_nxt;

// driver supply faults only mask the drivers; the stored command is untouched
assign allow    = en_s && !vs_uv_s && !(vs_ov_s && cmd_overvoltage_lockout_enable_r);
assign drive_hs = allow ? (cmd_en_r & ~off_latch_r & cmd_cfg_r) : 6'h0;
assign drive_ls = allow ? (cmd_en_r & ~off_latch_r & ~cmd_cfg_r) : 6'h0;

always_comb begin
    for (int i = 0; i < 6; i++) begin
        if (off_latch_r[i] && !tsd_s[i] && oc_flag_r) begin
            code_nxt[2*i +: 2] = hbfs_pkg::HB_CODE_OC;
        end else if (off_latch_r[i] && ul_flag_r) begin
            code_nxt[2*i +: 2] = hbfs_pkg::HB_CODE_UL;
        end else begin
            code_nxt[2*i +: 2] = hbfs_pkg::HB_CODE_OK;
        end
    end
end

// complementary drive per bridge keeps high and low side exclusive
always_ff @(posedge clk) begin
    if (rst || wipe) begin
        hs_on_r         <= 6'h0;
        ls_on_r         <= 6'h0;
        status_r        <= 16'h0;
        hb_code_r       <= 12'h0;
        frame_applied_r <= 1'b0;
    end else begin
        hs_on_r  <= drive_hs & ~trip;
        ls_on_r  <= drive_ls & ~trip;
        status_r <= {oc_flag_r || (|oc_trip),
                     vs_uv_s || vs_ov_s,
                     ul_flag_r || (|ul_hit),
                     cmd_en_r & ~trip,
                     cmd_cfg_r & ~trip,
                     |tw_s};
        hb_code_r       <= code_nxt;
        frame_applied_r <= frame_take;
    end
end

////////////////////////////////////////////////////////////////////////////
// checks

property p_vcc_off;
    @(posedge clk) disable iff (rst)
    vcc_uv_s |=> (hs_on_r == 6'h0) && (ls_on_r == 6'h0) &&
                 (status_r == 16'h0);
endproperty
a_vcc_off: assert property (p_vcc_off)
    else $error("outputs or status alive in logic undervoltage");

property p_vs_uv;
    @(posedge clk) disable iff (rst)
    vs_uv_s && !vcc_uv_s |=> (hs_on_r == 6'h0) && (ls_on_r == 6'h0)
                             && status_r[`HBFS_ST_PSF];
endproperty
a_vs_uv: assert property (p_vs_uv)
    else $error("driver undervoltage left a driver on");

property p_ov_flag;
    @(posedge clk) disable iff (rst)
    vs_ov_s && !vcc_uv_s |=> status_r[`HBFS_ST_PSF];
endproperty
a_ov_flag: assert property (p_ov_flag)
    else $error("overvoltage not reported");

property p_overvoltage_lockout_enable_off;
    @(posedge clk) disable iff (rst)
    vs_ov_s && cmd_overvoltage_lockout_enable_r && !vcc_uv_s |=> (hs_on_r | ls_on_r) == 6'h0;
endproperty
a_overvoltage_lockout_enable_off: assert property (p_overvoltage_lockout_enable_off)
    else $error("lockout did not switch outputs off");

property p_oc_filter;
    @(posedge clk) disable iff (rst)
    oc_trip[0] |-> $past(oc_s[0], 2) && $past(oc_s[0], 1);
endproperty
a_oc_filter: assert property (p_oc_filter)
    else $error("overcurrent tripped without a sustained level");

property p_oc_report;
    @(posedge clk) disable iff (rst)
    (|oc_trip) && !vcc_uv_s |=> status_r[`HBFS_ST_OC] ##1
        (hb_code_r != 12'h0 || !oc_flag_r || vcc_uv_s);
endproperty
a_oc_report: assert property (p_oc_report)
    else $error("overcurrent shutdown not reported");

property p_ul_hold;
    @(posedge clk) disable iff (rst)
    ul_flag_r && !status_reset_request && en_s && !vcc_uv_s |=> ul_flag_r;
endproperty
a_ul_hold: assert property (p_ul_hold)
    else $error("underload flag dropped without a reset request");

property p_bad_frame;
    @(posedge clk) disable iff (rst)
    cs_rise && !lk_ok_r && !vcc_uv_s |=>
        $stable(cmd_overvoltage_lockout_enable_r) && $stable(cmd_underload_shutdown_ctrl_r) && !frame_applied_r;
endproperty
a_bad_frame: assert property (p_bad_frame)
    else $error("invalid frame changed the command");

property p_tsd_hold;
    @(posedge clk) disable iff (rst)
    tsd_flag_r && (|tsd_s) && en_s && !vcc_uv_s |=> tsd_flag_r;
endproperty
a_tsd_hold: assert property (p_tsd_hold)
    else $error("thermal latch cleared while still hot");

endmodule
`default_nettype wire

// File: spi_host_model.sv
// host side model that frames commands onto the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic link_sclk,
    output logic spi_cs_n,
    output logic spi_si
);
    // link clock stands still and select stays high between frames
    initial begin
        link_sclk = 1'b0;
        spi_cs_n  = 1'b1;
        spi_si    = 1'b0;
    end
    // n bits msb first at a 125 ns link period; the 7 ns start keeps the
    // link edges off the device clock grid
    task automatic send(input logic [23:0] w, input int n);
        int i;
        #7;
        spi_cs_n = 1'b0;
        #100;
        for (i = n - 1; i >= 0; i--) begin
            spi_si = w[i];
            #62.5;
            link_sclk = 1'b1;
            #62.5;
            link_sclk = 1'b0;
        end
        // data no longer held: show the inverse of the last bit
        spi_si = ~spi_si;
        #50;
        spi_cs_n = 1'b1;
        // select gap well above 200 ns before the next frame
        #300;
    endtask
endmodule
`default_nettype wire

// File: half_bridge_fault_supervisor_bench.sv
// self-checking bench for the half-bridge fault supervisor
`timescale 1ns/1ps
`default_nettype none
module half_bridge_fault_supervisor_bench;
    localparam logic [15:0] c_run  = 16'h1fd5;
    localparam logic [15:0] c_nolo = 16'h1fd4;
    localparam logic [15:0] c_srr  = 16'h9fd5;
    localparam logic [15:0] c_uls  = 16'h3fd5;
    localparam logic [15:0] c_ulsr = 16'hbfd5;
    localparam logic [15:0] s_run  = 16'h1fd4;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        en_pin = 1'b1;
    logic        vcc_uv = 1'b0;
    logic        vs_uv = 1'b0;
    logic        vs_ov = 1'b0;
    logic [5:0]  oc_det = 6'h00;
    logic [5:0]  ul_det = 6'h00;
    logic [5:0]  tw_det = 6'h00;
    logic [5:0]  tsd_det = 6'h00;
    logic        link_sclk;
    logic        spi_cs_n;
    logic        spi_si;
    logic [5:0]  hs_on_r;
    logic [5:0]  ls_on_r;
    logic [15:0] status_r;
    logic [11:0] hb_code_r;
    logic        tsd_flag_r;
    logic        frame_applied_r;
    int          fails = 0;
    int          n_compared = 0;

    half_bridge_fault_supervisor uut (
        .clk(clk), .rst(rst), .link_sclk(link_sclk),
        .spi_cs_n(spi_cs_n), .spi_si(spi_si), .en_pin(en_pin),
        .vcc_uv(vcc_uv), .vs_uv(vs_uv), .vs_ov(vs_ov),
        .oc_det(oc_det), .ul_det(ul_det), .tw_det(tw_det),
        .tsd_det(tsd_det), .hs_on_r(hs_on_r), .ls_on_r(ls_on_r),
        .status_r(status_r), .hb_code_r(hb_code_r),
        .tsd_flag_r(tsd_flag_r), .frame_applied_r(frame_applied_r)
    );
    spi_host_model host (
        .link_sclk(link_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si)
    );

    ////////////////////////////////////////////////////////////////////
    // 20 MHz device clock
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic test_done;
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask

    // drive pattern as {hs, ls} and the whole status word
    task automatic outs(input logic [11:0] o, input logic [15:0] s);
        chk({4'h0, hs_on_r, ls_on_r}, {4'h0, o});
        chk(status_r, s);
    endtask

    // one frame; only 16 or 24 bit frames may raise the load pulse
    task automatic frame(input logic [23:0] w, input int n);
        int k;
        int seen;
        seen = 0;
        fork
            host.send(w, n);
        join_none
        for (k = 0; k < 90; k++) begin
            @(negedge clk);
            if (frame_applied_r === 1'b1)
                seen++;
        end
        chk(16'(seen), 16'((n == 16 || n == 24) ? 1 : 0));
    endtask

    ////////////////////////////////////////////////////////////////////
    // hang guard, well past the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        $display("mismatch at %0t: watchdog expired", $time);
        fails++;
        test_done();
    end

    // main sequence; stimulus changes on falling edges only
    initial begin
        tick(20);
        rst = 1'b0;
        tick(1);
        outs(12'h000, 16'h0000);
        chk({4'h0, hb_code_r}, 16'h0000);
        frame(c_run, 16);
        outs(12'ha95, s_run);
        frame(24'h000000, 15);
        outs(12'ha95, s_run);
        // driver supply low then back
        vs_uv = 1'b1;
        tick(5);
        outs(12'h000, 16'h5fd4);
        vs_uv = 1'b0;
        tick(5);
        outs(12'ha95, s_run);
        // overvoltage with and without lockout
        vs_ov = 1'b1;
        tick(5);
        outs(12'h000, 16'h5fd4);
        vs_ov = 1'b0;
        tick(5);
        outs(12'ha95, s_run);
        frame({8'h5a, c_nolo}, 24);
        vs_ov = 1'b1;
        tick(5);
        outs(12'ha95, 16'h5fd4);
        vs_ov = 1'b0;
        frame(c_run, 16);
        // overcurrent on bridge 1 low side: filter then latch
        oc_det = 6'h01;
        tick(190);
        outs(12'ha95, s_run);
        tick(25);
        outs(12'ha94, 16'h9f54);
        chk({4'h0, hb_code_r}, 16'h0001);
        oc_det = 6'h00;
        // the reload shows bridge 1 enabled, but the latch keeps it off
        frame(c_run, 16);
        outs(12'ha94, 16'h9fd4);
        frame({8'h00, c_srr}, 17);
        outs(12'ha94, 16'h9fd4);
        frame(c_srr, 16);
        outs(12'ha95, s_run);
        chk({4'h0, hb_code_r}, 16'h0000);
        // underload with shutdown: second bridge joins the running timer
        frame(c_uls, 16);
        ul_det = 6'h01;
        tick(2000);
        ul_det = 6'h05;
        tick(1990);
        outs(12'ha95, s_run);
        tick(20);
        outs(12'ha90, 16'h3d54);
        chk({4'h0, hb_code_r}, 16'h0022);
        ul_det = 6'h00;
        tick(5);
        outs(12'ha90, 16'h3d54);
        frame(c_ulsr, 16);
        outs(12'ha95, s_run);
        // underload without shutdown, cleared by cycling the enable pin
        frame(c_run, 16);
        ul_det = 6'h01;
        tick(4010);
        outs(12'ha95, 16'h3fd4);
        ul_det = 6'h00;
        en_pin = 1'b0;
        tick(5);
        en_pin = 1'b1;
        tick(5);
        outs(12'ha95, s_run);
        // thermal warning, then shutdown on bridge 5
        tw_det = 6'h08;
        tick(5);
        outs(12'ha95, 16'h1fd5);
        tw_det = 6'h00;
        tick(5);
        outs(12'ha95, s_run);
        tsd_det = 6'h10;
        tick(5);
        outs(12'ha85, 16'h17d4);
        chk({15'h0000, tsd_flag_r}, 16'h0001);
        frame(c_srr, 16);
        chk({15'h0000, tsd_flag_r}, 16'h0001);
        tsd_det = 6'h00;
        frame(c_srr, 16);
        chk({15'h0000, tsd_flag_r}, 16'h0000);
        outs(12'ha95, s_run);
        // logic supply undervoltage wipes command and status
        vcc_uv = 1'b1;
        tick(5);
        outs(12'h000, 16'h0000);
        vcc_uv = 1'b0;
        tick(5);
        outs(12'h000, 16'h0000);
        test_done();
    end
endmodule
`default_nettype wire
